//--- inc/cog_pkg.sv
// Purpose: shared constants for the converter control device and its serial host
// Assumes: 24-bit frame, first bit read flag, then 7-bit address, then 16-bit data
// Notes: all register addresses and field positions live here
`default_nettype none
package cog_pkg;
  // clock and link framing
  localparam int CLK_MHZ = 50;
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 8;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int SCLK_HALF_CYC = 4;
  // channel counts and widths
  localparam int DAC_N = 4;
  localparam int DAC_W = 10;
  localparam int GPIO_N = 12;
  // device register addresses
  localparam logic [6:0] A_TEMP_RATE = 7'h01;
  localparam logic [6:0] A_CONFIG = 7'h02;
  localparam logic [6:0] A_POWER = 7'h03;
  localparam logic [6:0] A_DAC_SYNC = 7'h04;
  localparam logic [6:0] A_DAC_CLEAR = 7'h05;
  localparam logic [6:0] A_GPIO_DIR = 7'h06;
  localparam logic [6:0] A_GPIO_OUT = 7'h07;
  localparam logic [6:0] A_GPIO_IN = 7'h08;
  localparam logic [6:0] A_RESET = 7'h09;
  localparam logic [6:0] A_DAC_DATA = 7'h10;
  localparam logic [6:0] A_DAC_CLRV = 7'h18;
  // field positions
  localparam int LOAD_BIT = 11;
  localparam int REF_ON_BIT = 13;
  // reset values and keys
  localparam logic [2:0] TEMP_RATE_RST = 3'h7;
  localparam logic [15:0] POWER_RST = 16'h0000;
  localparam logic [9:0] DAC_RST = 10'h000;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h6600;
  // reset wait time, in microseconds and in clock cycles
  localparam int RESET_WAIT_US = 200;
  localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
  // host command port addresses
  localparam logic [1:0] H_CMD = 2'h0;
  localparam logic [1:0] H_STAT = 2'h1;
  localparam logic [1:0] H_RX = 2'h2;
endpackage
`default_nettype wire

//--- inc/cog_link_if.sv
// Purpose: four-wire serial link between host and device
// Assumes: host drives select, clock and data out; device drives data back
// Notes: no clocking block; both ends sample through their own synchronisers
`default_nettype none
interface cog_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport host (output cs_n, output sclk, output mosi, input miso);
  modport dev (input cs_n, input sclk, input mosi, output miso);
endinterface
`default_nettype wire

//--- rtl/cog_dev.sv
// Purpose: control logic of the monitor-and-control device behind the serial link
// Assumes: link pins arrive asynchronously and are sampled on clock_i
// Notes: writes take effect at frame end; reads answer in the same frame
//
// How it works
// - temperature rate code 111 default, slower lower
// - power bit 13 selects internal reference
// - reference select comes up cleared
// - reset powers down all analog outputs
// - channel data read returns latch
// - async channel write updates latch immediately
// - sync channel waits for global load strobe
// - load reloads only channels written since
// - clear bit drives preset value out
// - clear released returns output to latch
// - direction one drives pin from out
// - direction zero floats pin, captures input
// - all pins input after reset
// - host silent during power-up wait
// - key 0x6600 to reset register resets all
// - host waits after soft reset frame
// - host should soft reset before configuring
// - power register default switches everything off
//
// Our own choices: the address map and the address-and-strobe port.
`default_nettype none
module cog_dev (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // serial link
  cog_link_if.dev lnk,
  // converter outputs
  output logic [cog_pkg::DAC_N*cog_pkg::DAC_W-1:0] analog_out_pin_code_o,
  output logic [cog_pkg::DAC_N-1:0] analog_out_pin_en_o,
  output logic ref_internal_o,
  output logic [2:0] temp_rate_o,
  // general purpose pins
  input wire logic [cog_pkg::GPIO_N-1:0] general_io_pin_i,
  output logic [cog_pkg::GPIO_N-1:0] general_io_pin_o,
  output logic [cog_pkg::GPIO_N-1:0] general_io_pin_oe_o
);
  import cog_pkg::*;

  logic [1:0] csn_sy;
  logic [1:0] sclk_sy;
  logic [1:0] mosi_sy;
  logic csn_d;
  logic sclk_d;
  logic [GPIO_N-1:0] gp_s1;
  logic [GPIO_N-1:0] gp_s2;
  logic [4:0] cnt;
  logic [FRAME_BITS-1:0] rx;
  logic [DATA_W-1:0] tx;
  logic [ADDR_W-1:0] addr_q;
  logic rw_q;
  logic [2:0] temp_rate;
  logic [DATA_W-1:0] power;
  logic [DAC_N-1:0] dac_sync;
  logic [DAC_N-1:0] dac_clr;
  logic [DAC_N-1:0] pend;
  logic [GPIO_N-1:0] gp_dir;
  logic [GPIO_N-1:0] gp_out;
  logic [GPIO_N-1:0] gp_in;
  logic [DAC_W-1:0] dac_data [DAC_N];
  logic [DAC_W-1:0] dac_latch [DAC_N];
  logic [DAC_W-1:0] dac_clrv [DAC_N];

  // link pins pass two flops before any logic looks at them
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      csn_sy <= 2'h3;
      sclk_sy <= 2'h0;
      mosi_sy <= 2'h0;
      csn_d <= 1'b1;
      sclk_d <= 1'b0;
      gp_s1 <= '0;
      gp_s2 <= '0;
    end else begin
      csn_sy <= {csn_sy[0], lnk.cs_n};
      sclk_sy <= {sclk_sy[0], lnk.sclk};
      mosi_sy <= {mosi_sy[0], lnk.mosi};
      csn_d <= csn_sy[1];
      sclk_d <= sclk_sy[1];
      gp_s1 <= general_io_pin_i;
      gp_s2 <= gp_s1;
    end
  end

  // edge finding on the synchronised copies
  wire sel_w = ~csn_sy[1];
  wire rise_w = sel_w & sclk_sy[1] & ~sclk_d;
  wire frame_end_w = csn_sy[1] & ~csn_d;
  wire [HDR_BITS-1:0] hdr_w = {rx[HDR_BITS-2:0], mosi_sy[1]};
  wire hdr_done_w = rise_w & (cnt == 5'(HDR_BITS - 1));

  // write decode, only a whole frame counts
  wire [DATA_W-1:0] wdat_w = rx[DATA_W-1:0];
  wire wr_w = frame_end_w & (cnt == 5'(FRAME_BITS)) & ~rw_q;
  wire wr_temp_w = wr_w & (addr_q == A_TEMP_RATE);
  wire wr_pow_w = wr_w & (addr_q == A_POWER);
  wire wr_sync_w = wr_w & (addr_q == A_DAC_SYNC);
  wire wr_clr_w = wr_w & (addr_q == A_DAC_CLEAR);
  wire wr_dir_w = wr_w & (addr_q == A_GPIO_DIR);
  wire wr_gout_w = wr_w & (addr_q == A_GPIO_OUT);
  wire wr_dac_w = wr_w & (addr_q[6:2] == A_DAC_DATA[6:2]);
  wire wr_clrv_w = wr_w & (addr_q[6:2] == A_DAC_CLRV[6:2]);
  wire soft_w = wr_w & (addr_q == A_RESET) & (wdat_w == SOFT_RESET_KEY);
  // load is a strobe: nothing stores it, so it reads back as zero
  wire load_w = wr_w & (addr_q == A_CONFIG) & wdat_w[LOAD_BIT];

  // read mux, selected on the address that completes in this edge
  wire [6:0] ra_w = hdr_w[6:0];
  wire [1:0] rch_w = ra_w[1:0];
  wire [DATA_W-1:0] rd_w =
    (ra_w == A_TEMP_RATE) ? {13'h0000, temp_rate} :
    (ra_w == A_POWER) ? power :
    (ra_w == A_DAC_SYNC) ? {12'h000, dac_sync} :
    (ra_w == A_DAC_CLEAR) ? {12'h000, dac_clr} :
    (ra_w == A_GPIO_DIR) ? {4'h0, gp_dir} :
    (ra_w == A_GPIO_OUT) ? {4'h0, gp_out} :
    (ra_w == A_GPIO_IN) ? {4'h0, gp_in} :
    (ra_w[6:2] == A_DAC_DATA[6:2]) ? {6'h00, dac_latch[rch_w]} :
    (ra_w[6:2] == A_DAC_CLRV[6:2]) ? {6'h00, dac_clrv[rch_w]} :
    16'h0000;

  // frame shifter: sample on rise, present read data after the header
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 5'h00;
      rx <= '0;
      tx <= '0;
      addr_q <= '0;
      rw_q <= 1'b0;
    end else if (!sel_w) begin
      cnt <= 5'h00;
      tx <= '0;
    end else if (rise_w) begin
      rx <= {rx[FRAME_BITS-2:0], mosi_sy[1]};
      cnt <= (cnt == 5'h1F) ? cnt : cnt + 5'h01;
      if (hdr_done_w) begin
        addr_q <= hdr_w[6:0];
        rw_q <= hdr_w[7];
        tx <= hdr_w[7] ? rd_w : 16'h0000;
      end else begin
        tx <= {tx[DATA_W-2:0], 1'b0};
      end
    end
  end
  assign lnk.miso = tx[DATA_W-1];

  // control registers; power and reference come up off
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      temp_rate <= TEMP_RATE_RST;
      power <= POWER_RST;
      dac_sync <= '0;
      dac_clr <= '0;
      gp_dir <= '0;
      gp_out <= '0;
    end else if (soft_w) begin
      // key frame is a synchronous reset; kept apart from the pin reset
      temp_rate <= TEMP_RATE_RST;
      power <= POWER_RST;
      dac_sync <= '0;
      dac_clr <= '0;
      gp_dir <= '0;
      gp_out <= '0;
    end else begin
      if (wr_temp_w) temp_rate <= wdat_w[2:0];
      if (wr_pow_w) power <= wdat_w;
      if (wr_sync_w) dac_sync <= wdat_w[DAC_N-1:0];
      if (wr_clr_w) dac_clr <= wdat_w[DAC_N-1:0];
      if (wr_dir_w) gp_dir <= wdat_w[GPIO_N-1:0];
      if (wr_gout_w) gp_out <= wdat_w[GPIO_N-1:0];
    end
  end

  // input register follows only pins set as inputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gp_in <= '0;
    end else begin
      gp_in <= (gp_in & gp_dir) | (gp_s2 & ~gp_dir);
    end
  end

  // channel data, latches and clear presets
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DAC_N; i++) begin
        dac_data[i] <= DAC_RST;
        dac_latch[i] <= DAC_RST;
        dac_clrv[i] <= DAC_RST;
      end
      pend <= '0;
    end else if (soft_w) begin
      for (int i = 0; i < DAC_N; i++) begin
        dac_data[i] <= DAC_RST;
        dac_latch[i] <= DAC_RST;
        dac_clrv[i] <= DAC_RST;
      end
      pend <= '0;
    end else begin
      for (int i = 0; i < DAC_N; i++) begin
        if (wr_dac_w && addr_q[1:0] == 2'(i)) begin
          dac_data[i] <= wdat_w[DAC_W-1:0];
          if (!dac_sync[i]) begin
            dac_latch[i] <= wdat_w[DAC_W-1:0];
          end else begin
            pend[i] <= 1'b1;
          end
        end else if (load_w && pend[i]) begin
          dac_latch[i] <= dac_data[i];
          pend[i] <= 1'b0;
        end
        if (wr_clrv_w && addr_q[1:0] == 2'(i)) begin
          dac_clrv[i] <= wdat_w[DAC_W-1:0];
        end
      end
    end
  end

  // output code: clear preset wins over the latch while clear is set
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_out_pin_code_o <= '0;
    end else begin
      for (int i = 0; i < DAC_N; i++) begin
        analog_out_pin_code_o[i*DAC_W +: DAC_W] <=
          dac_clr[i] ? dac_clrv[i] : dac_latch[i];
      end
    end
  end

  // buffers enabled only by power bits; low means high-z with ground pull
  assign analog_out_pin_en_o = power[DAC_N-1:0];
  assign ref_internal_o = power[REF_ON_BIT];
  assign temp_rate_o = temp_rate;
  assign general_io_pin_o = gp_out;
  assign general_io_pin_oe_o = gp_dir;
endmodule
`default_nettype wire

//--- rtl/cog_host.sv
// Purpose: serial host that runs frames to the device on software command
// Assumes: software port with one-cycle strobes, read data the next cycle
// Notes: holds off the link after reset and after a soft reset frame
`default_nettype none
module cog_host #(
  parameter int WAIT_CYC = cog_pkg::RESET_WAIT_CYC,
  parameter int HALF_CYC = cog_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // software port
  input wire logic [1:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [23:0] rdata_o,
  // serial link
  cog_link_if.host lnk
);
  import cog_pkg::*;

  typedef enum logic [2:0] {
    COG_IDLE = 3'h0,
    COG_LOW = 3'h1,
    COG_HIGH = 3'h3,
    COG_FIN = 3'h2,
    COG_HOLD = 3'h6
  } cog_state_t;

  cog_state_t state;
  logic [15:0] hold;
  logic [7:0] div;
  logic [4:0] bitn;
  logic [FRAME_BITS-1:0] txs;
  logic [FRAME_BITS-1:0] rxs;
  logic [DATA_W-1:0] rx_word;
  logic [1:0] miso_sy;
  logic is_soft;

  // start only when idle; a command while busy or holding is dropped
  wire start_w = wr_i & (addr_i == H_CMD) & (state == COG_IDLE);
  wire tick_w = (div == 8'(HALF_CYC - 1));
  wire [DATA_W-1:0] stat_w = {14'h0000, state == COG_HOLD, state != COG_IDLE};
  wire soft_w = (txs[22:16] == A_RESET) & ~txs[23]
    & (txs[DATA_W-1:0] == SOFT_RESET_KEY);

  // returned data bit passes two flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_sy <= 2'h0;
    end else begin
      miso_sy <= {miso_sy[0], lnk.miso};
    end
  end

  // frame sequencer; the clock is divided down here and driven out
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= COG_HOLD;
      hold <= 16'(WAIT_CYC);
      div <= 8'h00;
      bitn <= 5'h00;
      txs <= '0;
      rxs <= '0;
      rx_word <= '0;
      is_soft <= 1'b0;
      lnk.cs_n <= 1'b1;
      lnk.sclk <= 1'b0;
      lnk.mosi <= 1'b0;
    end else begin
      div <= tick_w ? 8'h00 : div + 8'h01;
      case (state)
        COG_IDLE: begin
          div <= 8'h00;
          if (start_w) begin
            txs <= wdata_i;
            is_soft <= 1'b0;
            bitn <= 5'h00;
            lnk.cs_n <= 1'b0;
            lnk.mosi <= wdata_i[FRAME_BITS-1];
            state <= COG_LOW;
          end
        end
        COG_LOW: begin
          if (tick_w) begin
            rxs <= {rxs[FRAME_BITS-2:0], miso_sy[1]};
            lnk.sclk <= 1'b1;
            state <= COG_HIGH;
          end
        end
        COG_HIGH: begin
          if (tick_w) begin
            lnk.sclk <= 1'b0;
            if (bitn == 5'(FRAME_BITS - 1)) begin
              is_soft <= soft_w;
              rx_word <= rxs[DATA_W-1:0];
              state <= COG_FIN;
            end else begin
              bitn <= bitn + 5'h01;
              lnk.mosi <= txs[FRAME_BITS - 2 - int'(bitn)];
              state <= COG_LOW;
            end
          end
        end
        COG_FIN: begin
          if (tick_w) begin
            lnk.cs_n <= 1'b1;
            hold <= 16'(WAIT_CYC);
            // soft reset frame: wait counted from select rising
            state <= is_soft ? COG_HOLD : COG_IDLE;
          end
        end
        COG_HOLD: begin
          hold <= hold - 16'h0001;
          if (hold <= 16'h0001) begin
            state <= COG_IDLE;
          end
        end
        default: state <= COG_IDLE;
      endcase
    end
  end

  // read port answers one cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= (addr_i == H_STAT) ? {8'h00, stat_w} :
                 (addr_i == H_RX) ? {8'h00, rx_word} : 24'h000000;
    end
  end
endmodule
`default_nettype wire

//--- verification/cog_chk.sv
// Purpose: link and output checks beside the host-device link
// Assumes: both ends run on clock_i
// Notes: only the soft reset frame is decoded here
`default_nettype none
module cog_chk #(
  parameter int WAIT_CYC = cog_pkg::RESET_WAIT_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // link
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  // device outputs
  input wire logic [3:0] dac_en_i,
  input wire logic ref_on_i,
  input wire logic [2:0] temp_rate_i,
  input wire logic [11:0] pin_oe_i
);
  import cog_pkg::*;
  logic cs_q, sclk_q, sres;
  logic [23:0] sh;
  logic [5:0] nrise;
  int pw_cnt, sr_cnt;
  // key frame seen in the first cycle with select released
  assign sres = cs_n_i && !cs_q && nrise == 6'h18 && sh == {1'b0, A_RESET, SOFT_RESET_KEY};
  // frame decode; a short frame never counts as the key, a long one only at 24 plus a multiple of 64 rises, as the 6-bit count wraps
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      sh <= 24'h000000;
      nrise <= 6'h00;
    end else begin
      cs_q <= cs_n_i;
      sclk_q <= sclk_i;
      if (!cs_n_i && cs_q) nrise <= 6'h00;
      else if (sclk_i && !sclk_q) nrise <= nrise + 6'h01;
      if (sclk_i && !sclk_q) sh <= {sh[22:0], mosi_i};
    end
  end
  // quiet windows after reset release and after the key frame
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pw_cnt <= WAIT_CYC;
      sr_cnt <= 0;
    end else begin
      if (pw_cnt != 0) pw_cnt <= pw_cnt - 1;
      if (sres) sr_cnt <= WAIT_CYC - 1;
      else if (sr_cnt != 0) sr_cnt <= sr_cnt - 1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence key_s;
    sres;
  endsequence
  sequence off_s;
    dac_en_i == 4'h0 && !ref_on_i;
  endsequence
  sequence dflt_s;
    temp_rate_i == TEMP_RATE_RST && pin_oe_i == 12'h000;
  endsequence
  // host stays off the link in both quiet windows
  power_hold_a: assert property (pw_cnt != 0 |-> cs_n_i)
    else $error("link busy in power-up wait");
  sreset_hold_a: assert property (sr_cnt != 0 |-> cs_n_i)
    else $error("link busy in soft reset wait");
  sreset_off_a: assert property (key_s |-> ##[1:8] off_s)
    else $error("analog left on after soft reset");
  sreset_dflt_a: assert property (key_s |-> ##[1:8] dflt_s)
    else $error("defaults missing after soft reset");
  // outputs at the first edge after any pin reset
  ref_reset_a: assert property ($rose(rst_n_i) |-> !ref_on_i)
    else $error("reference select set at reset");
  dac_reset_a: assert property ($rose(rst_n_i) |-> dac_en_i == 4'h0)
    else $error("output buffer on at reset");
  pin_reset_a: assert property ($rose(rst_n_i) |-> pin_oe_i == 12'h000)
    else $error("pin driven at reset");
  rate_reset_a: assert property ($rose(rst_n_i) |-> temp_rate_i == TEMP_RATE_RST)
    else $error("rate code wrong at reset");
  // link shape: clock parked outside frames, fixed high time, whole frames
  sclk_idle_a: assert property (cs_n_i |-> !sclk_i)
    else $error("serial clock moves outside frame");
  sclk_high_a: assert property ($rose(sclk_i) |-> sclk_i [*4] ##1 !sclk_i)
    else $error("serial clock high time wrong");
  frame_len_a: assert property ($rose(cs_n_i) |-> nrise == 6'h18)
    else $error("frame not 24 bits");
  // returned data line rests low while the device is deselected
  miso_idle_a: assert property (cs_n_i && cs_q |-> !miso_i)
    else $error("data line active outside frame");
endmodule
`default_nettype wire

//--- verification/cog_tb.sv
// Purpose: self-checking bench for host and device joined by the link
// Assumes: one clock for both ends, shortened reset wait
// Notes: a register model predicts every output and read
`default_nettype none
module cog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cog_pkg::*;
  localparam int WAIT = 20;
  logic clock_i, rst_n_i, wr, rd, ref_on;
  logic [1:0] addr;
  logic [23:0] wdata, rdata;
  logic [39:0] code;
  logic [3:0] en, m_sync, m_clr, m_pend;
  logic [2:0] trate, m_temp;
  logic [11:0] pin_o, pin_oe, ext, pin_lvl, m_dir, m_out, m_gin;
  logic [31:0] lfsr;
  logic [15:0] m_pow;
  logic [9:0] m_data[4], m_lat[4], m_clv[4];
  logic [6:0] tbl[16];
  int n_mismatch, num_checks, k;
  cog_link_if lnk_if();
  cog_host #(.WAIT_CYC(WAIT), .HALF_CYC(SCLK_HALF_CYC)) cog_host_inst (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .lnk(lnk_if.host));
  cog_dev cog_dev_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .lnk(lnk_if.dev),
    .analog_out_pin_code_o(code), .analog_out_pin_en_o(en), .ref_internal_o(ref_on),
    .temp_rate_o(trate), .general_io_pin_i(pin_lvl), .general_io_pin_o(pin_o),
    .general_io_pin_oe_o(pin_oe));
  cog_chk #(.WAIT_CYC(WAIT)) cog_chk_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .cs_n_i(lnk_if.cs_n), .sclk_i(lnk_if.sclk), .mosi_i(lnk_if.mosi), .miso_i(lnk_if.miso),
    .dac_en_i(en), .ref_on_i(ref_on), .temp_rate_i(trate), .pin_oe_i(pin_oe));
  // driven bits follow the device, floating ones the bench
  assign pin_lvl = (pin_o & pin_oe) | (ext & ~pin_oe);
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_out(input string nm, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_rd(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one strobe cycle; read data lands on the following edge
  task automatic sw(input logic [1:0] a, input logic [23:0] d, input logic w);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  // poll until neither busy nor holding
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      sw(H_STAT, 24'h000000, 1'b0);
      if (rdata[1:0] === 2'b00) return;
    end
    n_mismatch++;
    test_done();
  endtask
  task automatic m_rst();
    m_pow = POWER_RST;
    m_temp = TEMP_RATE_RST;
    {m_sync, m_clr, m_pend, m_dir, m_out} = 36'h0;
    m_gin = ext;
    m_data = '{4{DAC_RST}};
    m_lat = '{4{DAC_RST}};
    m_clv = '{4{DAC_RST}};
  endtask
  task automatic m_wr(input logic [6:0] a, input logic [15:0] d);
    if (a[6:2] == A_DAC_DATA[6:2]) begin
      m_data[a[1:0]] = d[9:0];
      if (m_sync[a[1:0]]) m_pend[a[1:0]] = 1'b1;
      else m_lat[a[1:0]] = d[9:0];
    end
    if (a[6:2] == A_DAC_CLRV[6:2]) m_clv[a[1:0]] = d[9:0];
    if (a == A_TEMP_RATE) m_temp = d[2:0];
    if (a == A_POWER) m_pow = d;
    if (a == A_DAC_SYNC) m_sync = d[3:0];
    if (a == A_DAC_CLEAR) m_clr = d[3:0];
    if (a == A_GPIO_DIR) m_dir = d[11:0];
    if (a == A_GPIO_OUT) m_out = d[11:0];
    if (a == A_CONFIG && d[LOAD_BIT]) begin
      for (int i = 0; i < DAC_N; i++) if (m_pend[i]) m_lat[i] = m_data[i];
      m_pend = 4'h0;
    end
    if (a == A_RESET && d == SOFT_RESET_KEY) m_rst();
  endtask
  function automatic logic [15:0] m_rd(input logic [6:0] a);
    if (a[6:2] == A_DAC_DATA[6:2]) return {6'h00, m_lat[a[1:0]]};
    if (a[6:2] == A_DAC_CLRV[6:2]) return {6'h00, m_clv[a[1:0]]};
    case (a)
      A_TEMP_RATE: return {13'h0000, m_temp};
      A_POWER: return m_pow;
      A_DAC_SYNC: return {12'h000, m_sync};
      A_DAC_CLEAR: return {12'h000, m_clr};
      A_GPIO_DIR: return {4'h0, m_dir};
      A_GPIO_OUT: return {4'h0, m_out};
      A_GPIO_IN: return {4'h0, m_gin};
      default: return 16'h0000;
    endcase
  endfunction
  // random data kept inside each field
  function automatic logic [15:0] msk(input logic [6:0] a);
    if (a == A_CONFIG) return 16'h0800;
    if (a == A_POWER || a == A_GPIO_IN) return 16'hFFFF;
    if (a[4]) return 16'h03FF;
    if (a == A_TEMP_RATE) return 16'h0007;
    if (a >= A_GPIO_DIR) return 16'h0FFF;
    return 16'h000F;
  endfunction
  task automatic check();
    logic [39:0] ec;
    for (int i = 0; i < DAC_N; i++) ec[i*DAC_W +: DAC_W] = m_clr[i] ? m_clv[i] : m_lat[i];
    cmp_out("code", ec, code);
    cmp_out("analog", {32'h0, m_pow[13], m_pow[3:0], m_temp}, {32'h0, ref_on, en, trate});
    cmp_out("pins", {16'h0, m_out, m_dir}, {16'h0, pin_o, pin_oe});
  endtask
  // one frame; the pin capture is updated before and after a direction change
  task automatic op(input logic rw, input logic [6:0] a, input logic [15:0] d);
    m_gin = (ext & ~m_dir) | (m_gin & m_dir);
    wait_idle();
    sw(H_CMD, {rw, a, d}, 1'b1);
    wait_idle();
    repeat (6) @(posedge clock_i);
    #1;
    if (rw) begin
      sw(H_RX, 24'h000000, 1'b0);
      cmp_rd("read", m_rd(a), rdata[15:0]);
    end else m_wr(a, d);
    m_gin = (ext & ~m_dir) | (m_gin & m_dir);
    check();
  endtask
  initial begin
    {rst_n_i, wr, rd, addr, wdata} = 29'h0;
    ext = 12'h5A3;
    lfsr = 32'h3373A4DE;
    n_mismatch = 0;
    num_checks = 0;
    tbl = '{A_TEMP_RATE, A_CONFIG, A_POWER, A_DAC_SYNC, A_DAC_CLEAR, A_GPIO_DIR, A_GPIO_OUT,
      A_GPIO_IN, 7'h10, 7'h11, 7'h12, 7'h13, 7'h18, 7'h19, 7'h1A, 7'h1B};
    m_rst();
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check();
    op(1'b0, A_RESET, SOFT_RESET_KEY);
    for (k = 0; k < 8; k++) op(1'b0, A_TEMP_RATE, 16'(k));
    // channels 0 and 2 wait for the load; a read shows the latch, not the data
    op(1'b0, A_DAC_SYNC, 16'h0005);
    op(1'b0, 7'h10, 16'h0123);
    op(1'b0, 7'h11, 16'h0234);
    op(1'b1, 7'h10, 16'h0000);
    op(1'b0, A_CONFIG, 16'h0800);
    op(1'b1, A_CONFIG, 16'h0000);
    op(1'b1, 7'h10, 16'h0000);
    op(1'b0, 7'h1A, 16'h03AA);
    op(1'b0, A_DAC_CLEAR, 16'h0004);
    op(1'b0, A_DAC_CLEAR, 16'h0000);
    for (k = 0; k < 120; k++) begin
      lfsr = nxt(lfsr);
      @(posedge clock_i);
      ext <= lfsr[27:16];
      #1;
      op(lfsr[4], tbl[lfsr[3:0]], msk(tbl[lfsr[3:0]]) & lfsr[31:16]);
    end
    // pin reset in mid-run, with the registers holding random values
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    m_rst();
    @(posedge clock_i);
    #1;
    check();
    op(1'b0, A_RESET, 16'h6601);
    op(1'b0, A_RESET, SOFT_RESET_KEY);
    for (k = 0; k < 16; k++) op(1'b1, tbl[k], 16'h0000);
    op(1'b1, 7'h7F, 16'h0000);
    sw(2'h3, 24'h000000, 1'b0);
    cmp_rd("port", 16'h0000, rdata[15:0]);
    test_done();
  end
  // cut a hang short
  initial begin
    repeat (100000) @(posedge clock_i);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
